/* pit_core_timing.sv */
`timescale 1ns/1ps
module pit_core_timing
	import pit_pkg::*;
#(
	parameter int BW = 4,
	parameter int CPW = 5
) (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic issue_valid_i,
	input wire pit_cls_t cls_i,
	input wire logic shift_by_reg_i,
	input wire logic pc_dest_i,
	input wire logic byte_load_i,
	input wire logic [3:0] load_dest_i,
	input wire logic [15:0] reg_list_i,
	input wire logic [BW-1:0] busy_wait_i,
	input wire logic [CPW-1:0] cp_words_i,
	input wire logic unsigned_long_i,
	input wire logic [31:0] mul_operand_i,
	input wire logic [31:0] instr_i,
	input wire logic compact_i,
	input wire logic [15:0] next_src_mask_i,
	input wire logic imem_wait_i,
	input wire logic dmem_wait_i,
	output logic issue_ready_o,
	output logic fetch_hold_o,
	output logic instr_done_o,
	output pit_bus_t ibus_type_o,
	output pit_bus_t dbus_type_o,
	output logic [3:0] mul_op_reg_o
);

	generate
		if (BW < 1 || BW > 5 || CPW < 1 || CPW > 5) begin : g_bad
			$error("busy-wait or word-count width out of range");
		end
	endgenerate

	pit_state_t state_q, state_d;
	logic [LEN_W-1:0] cnt_q, cnt_d, len_q, len_d, base_q, base_d;
	logic [LEN_W-1:0] dstart_q, dstart_d, dcnt_q, dcnt_d;
	pit_bus_t dfirst_q, dfirst_d, dnext_q, dnext_d;
	logic refill_q, refill_d;
	logic ready_d, hold_d, done_d;
	pit_bus_t ibus_d, dbus_d;
	logic [3:0] opreg_d;

	logic stall, taken, last;
	logic [LEN_W-1:0] words, b, cpn, mlen;
	logic [15:0] dest_mask;
	logic use_any, use_top;
	logic [2:0] m_val;
	logic [3:0] op_reg;

	pit_hazard u_hazard (
		.dest_mask_i(dest_mask),
		.src_mask_i(next_src_mask_i),
		.use_o(use_any),
		.use_top_o(use_top)
	);

	pit_early_term u_early_term (
		.operand_i(mul_operand_i),
		.unsigned_i(unsigned_long_i && cls_i == CLS_LONG_MULTIPLY),
		.instr_i(instr_i),
		.compact_i(compact_i),
		.m_o(m_val),
		.op_reg_o(op_reg)
	);

	// Instruction-side type for cycle k; refill tail is N then S,S
	function automatic pit_bus_t ibus_of(logic [LEN_W-1:0] k, logic [LEN_W-1:0] len,
		logic refill);
		pit_bus_t t;
		t = BUS_I;
		if (refill && k >= len - REFILL_LEN) begin
			t = (k == len - REFILL_LEN) ? BUS_N : BUS_S;
		end else if (k == CNT_RST && !refill) begin
			t = BUS_S;
		end
		return t;
	endfunction

	// Data-side type for cycle k: a burst window, internal elsewhere
	function automatic pit_bus_t dbus_of(logic [LEN_W-1:0] k, logic [LEN_W-1:0] st,
		logic [LEN_W-1:0] n, pit_bus_t f, pit_bus_t r);
		pit_bus_t t;
		t = BUS_I;
		if (k >= st && k < st + n) begin
			t = (k == st) ? f : r;
		end
		return t;
	endfunction

	// Per-instruction timing profile, decided at issue
	always_comb begin
		words = '0;
		for (int i = 0; i < 16; i++) begin
			words = words + LEN_W'(reg_list_i[i]);
		end
		b = LEN_W'(busy_wait_i);
		cpn = LEN_W'(cp_words_i);
		mlen = LEN_W'(m_val);
		dest_mask = 16'h0000;
		unique case (cls_i)
			CLS_SINGLE_WORD_LOAD, CLS_ATOMIC_SWAP,
			CLS_COPROC_TO_CORE_MOVE: dest_mask = 16'h0001 << load_dest_i;
			CLS_BLOCK_LOAD: dest_mask = reg_list_i;
			default: dest_mask = 16'h0000;
		endcase
		len_d = ONE_CYC;
		base_d = ONE_CYC;
		refill_d = 1'b0;
		dstart_d = CNT_RST;
		dcnt_d = CNT_RST;
		dfirst_d = BUS_N;
		dnext_d = BUS_S;
		unique case (cls_i)
			CLS_DATA_OP: begin
				base_d = shift_by_reg_i ? SHIFT_REG_LEN : ONE_CYC;
			end
			CLS_SINGLE_WORD_LOAD: begin
				dcnt_d = ONE_CYC;
				if (pc_dest_i) begin
					base_d = LOAD_PC_LEN;
					refill_d = 1'b1;
				end else if (use_any && byte_load_i) begin
					len_d = NARROW_USE_LEN;
				end else if (use_any) begin
					len_d = LOAD_USE_LEN;
				end
			end
			CLS_SINGLE_WORD_STORE: begin
				dcnt_d = ONE_CYC;
			end
			CLS_BLOCK_LOAD: begin
				dcnt_d = words;
				if (pc_dest_i || reg_list_i[PC_IDX]) begin
					base_d = words + BLOCK_PC_EXTRA;
					refill_d = 1'b1;
				end else if (words == ONE_CYC) begin
					base_d = SINGLE_BLOCK_LEN;
					dfirst_d = BUS_S;
				end else begin
					base_d = words;
				end
				// Hold lasts to the final fetch; the top register costs one more
				if (use_top && !refill_d) begin
					len_d = base_d + ONE_CYC;
				end
			end
			CLS_BLOCK_STORE: begin
				dcnt_d = words;
				base_d = (words == ONE_CYC) ? SINGLE_BLOCK_LEN : words;
			end
			CLS_ATOMIC_SWAP: begin
				base_d = SWAP_LEN;
				dcnt_d = SWAP_LEN;
				dnext_d = BUS_N;
				if (use_any && byte_load_i) begin
					len_d = SWAP_USE_LEN;
				end
			end
			CLS_BRANCH, CLS_SOFTWARE_INTERRUPT, CLS_UNDEFINED: begin
				base_d = REFILL_LEN;
				refill_d = 1'b1;
			end
			CLS_COPROC_DATA_OP: begin
				base_d = b + ONE_CYC;
			end
			CLS_COPROC_MEM: begin
				base_d = b + cpn;
				dstart_d = b;
				dcnt_d = cpn;
			end
			CLS_CORE_TO_COPROC_MOVE, CLS_COPROC_TO_CORE_MOVE: begin
				base_d = b + ONE_CYC;
				dstart_d = b;
				dcnt_d = ONE_CYC;
				dfirst_d = BUS_C;
				if (cls_i == CLS_COPROC_TO_CORE_MOVE && use_any) begin
					len_d = b + ONE_CYC + ONE_CYC;
				end
			end
			CLS_MULTIPLY_32: begin
				base_d = MUL_BASE + mlen;
			end
			CLS_LONG_MULTIPLY: begin
				base_d = MULL_BASE + mlen;
			end
			default: begin
				base_d = ONE_CYC;
			end
		endcase
		// Interlock cycles follow the instruction's own cycles
		if (len_d < base_d) begin
			len_d = base_d;
		end
	end

	// Sequencer
	always_comb begin
		// Uncached accesses stretch the cycle for as long as the system asks
		stall = imem_wait_i || dmem_wait_i;
		taken = issue_valid_i && issue_ready_o && !stall;
		last = state_q == ST_RUN && cnt_q == len_q - ONE_CYC;
		state_d = state_q;
		cnt_d = cnt_q;
		done_d = 1'b0;
		opreg_d = mul_op_reg_o;
		if (taken) begin
			state_d = ST_RUN;
			cnt_d = CNT_RST;
			opreg_d = op_reg;
			done_d = last;
		end else if (state_q == ST_RUN && !stall) begin
			done_d = last;
			if (last) begin
				state_d = ST_IDLE;
				cnt_d = CNT_RST;
			end else begin
				cnt_d = cnt_q + ONE_CYC;
			end
		end
	end

	logic [LEN_W-1:0] len_n, base_n, dst_n, dcn_n;
	pit_bus_t df_n, dn_n;
	logic rf_n;

	always_comb begin
		len_n = taken ? len_d : len_q;
		base_n = taken ? base_d : base_q;
		dst_n = taken ? dstart_d : dstart_q;
		dcn_n = taken ? dcnt_d : dcnt_q;
		df_n = taken ? dfirst_d : dfirst_q;
		dn_n = taken ? dnext_d : dnext_q;
		rf_n = taken ? refill_d : refill_q;
		ready_d = state_d == ST_IDLE || cnt_d == len_n - ONE_CYC;
		// Interlock stops fetch and holds decode
		hold_d = state_d == ST_RUN && cnt_d >= base_n;
		ibus_d = BUS_I;
		dbus_d = BUS_I;
		if (state_d == ST_RUN) begin
			ibus_d = hold_d ? BUS_I : ibus_of(cnt_d, base_n, rf_n);
			dbus_d = dbus_of(cnt_d, dst_n, dcn_n, df_n, dn_n);
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= ST_IDLE;
			cnt_q <= CNT_RST;
			len_q <= ONE_CYC;
			base_q <= ONE_CYC;
			dstart_q <= CNT_RST;
			dcnt_q <= CNT_RST;
			dfirst_q <= BUS_I;
			dnext_q <= BUS_I;
			refill_q <= 1'b0;
			issue_ready_o <= 1'b1;
			fetch_hold_o <= 1'b0;
			instr_done_o <= 1'b0;
			ibus_type_o <= BUS_I;
			dbus_type_o <= BUS_I;
			mul_op_reg_o <= REG_RST;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			len_q <= len_n;
			base_q <= base_n;
			dstart_q <= dst_n;
			dcnt_q <= dcn_n;
			dfirst_q <= df_n;
			dnext_q <= dn_n;
			refill_q <= rf_n;
			issue_ready_o <= ready_d;
			fetch_hold_o <= hold_d;
			instr_done_o <= done_d;
			ibus_type_o <= ibus_d;
			dbus_type_o <= dbus_d;
			mul_op_reg_o <= opreg_d;
		end
	end

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	a_shift_len: assert property (taken && cls_i == CLS_DATA_OP && shift_by_reg_i
		|=> len_q == 6'h02 && ibus_type_o == BUS_S && dbus_type_o == BUS_I)
		else $error("register shift data op not two cycles");
	a_load_use: assert property (taken && cls_i == CLS_SINGLE_WORD_LOAD && !pc_dest_i
		&& use_any && !byte_load_i |=> len_q == 6'h02 && !fetch_hold_o)
		else $error("load-use interlock length wrong");
	a_narrow_use: assert property (taken && cls_i == CLS_SINGLE_WORD_LOAD && !pc_dest_i
		&& use_any && byte_load_i |=> len_q == 6'h03 && base_q == 6'h01)
		else $error("narrow load interlock wrong");
	a_pc_load: assert property (taken && cls_i == CLS_SINGLE_WORD_LOAD && pc_dest_i
		|=> len_q == 6'h05 && ibus_type_o == BUS_I && dbus_type_o == BUS_N)
		else $error("load to program counter wrong");
	a_block_pc: assert property (taken && cls_i == CLS_BLOCK_LOAD && reg_list_i[PC_IDX]
		|=> len_q == $past(words) + 6'h04)
		else $error("block load with program counter length wrong");
	a_swap_bus: assert property (taken && cls_i == CLS_ATOMIC_SWAP && !imem_wait_i
		|=> dbus_type_o == BUS_N ##1 (stall || dbus_type_o == BUS_N))
		else $error("swap data accesses not nonsequential");
	a_mul_len: assert property (taken && cls_i == CLS_LONG_MULTIPLY
		|=> len_q == 6'h03 + 6'($past(m_val)))
		else $error("long multiply length wrong");
	a_hold_nofetch: assert property (fetch_hold_o |-> ibus_type_o == BUS_I)
		else $error("fetch issued during interlock");
	a_wait_freeze: assert property (state_q == ST_RUN && stall
		|=> $stable(cnt_q) && $stable(ibus_type_o))
		else $error("cycle advanced during memory wait");
	a_refill_seq: assert property (taken && cls_i == CLS_BRANCH && !stall
		|=> ibus_type_o == BUS_N ##1 (stall || ibus_type_o == BUS_S))
		else $error("branch refill sequence wrong");
	a_top_dep: assert property (taken && cls_i == CLS_BLOCK_LOAD && use_top
		&& !reg_list_i[PC_IDX] && !pc_dest_i |=> len_q == base_q + 6'h01)
		else $error("top register interlock missing");

endmodule

/* pit_early_term.sv */
`timescale 1ns/1ps
module pit_early_term
	import pit_pkg::*;
(
	input wire logic [31:0] operand_i,
	input wire logic unsigned_i,
	input wire logic [31:0] instr_i,
	input wire logic compact_i,
	output logic [2:0] m_o,
	output logic [3:0] op_reg_o
);

	logic z1, z2, z3, o1, o2, o3;

	always_comb begin
		z1 = ~|operand_i[31:ET_LO];
		z2 = ~|operand_i[31:ET_MID];
		z3 = ~|operand_i[31:ET_HI];
		// All-ones only terminates early when the operand is signed
		o1 = &operand_i[31:ET_LO] && !unsigned_i;
		o2 = &operand_i[31:ET_MID] && !unsigned_i;
		o3 = &operand_i[31:ET_HI] && !unsigned_i;
		if (z1 || o1) begin
			m_o = 3'h1;
		end else if (z2 || o2) begin
			m_o = 3'h2;
		end else if (z3 || o3) begin
			m_o = 3'h3;
		end else begin
			m_o = 3'h4;
		end
		if (compact_i) begin
			op_reg_o = {1'b0, instr_i[MUL_RS_COMPACT_LSB +: 3]};
		end else begin
			op_reg_o = instr_i[MUL_RS_LSB +: 4];
		end
	end

endmodule

/* pit_hazard.sv */
`timescale 1ns/1ps
module pit_hazard
	import pit_pkg::*;
(
	input wire logic [15:0] dest_mask_i,
	input wire logic [15:0] src_mask_i,
	output logic use_o,
	output logic use_top_o
);

	logic [15:0] top;

	always_comb begin
		top = 16'h0000;
		// Highest register of the list lands last
		for (int i = 0; i < 16; i++) begin
			if (dest_mask_i[i]) begin
				top = 16'h0001 << i;
			end
		end
		use_o = |(dest_mask_i & src_mask_i);
		use_top_o = |(top & src_mask_i);
	end

endmodule

/* pit_mem_model.sv */
`timescale 1ns/1ps
module pit_mem_model
	import pit_pkg::*;
#(
	parameter int LAT = 2
) (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic i_slow_i,
	input wire logic d_slow_i,
	input wire pit_bus_t ibus_type_i,
	input wire pit_bus_t dbus_type_i,
	output logic imem_wait_o,
	output logic dmem_wait_o
);
	int i_cnt_q;
	int d_cnt_q;
	// In slow mode every real access misses the cache and is held off LAT cycles
	assign imem_wait_o = i_slow_i && ibus_type_i != BUS_I && i_cnt_q < LAT;
	assign dmem_wait_o = d_slow_i && dbus_type_i != BUS_I && d_cnt_q < LAT;
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			i_cnt_q <= 0;
			d_cnt_q <= 0;
		end else begin
			i_cnt_q <= imem_wait_o ? i_cnt_q + 1 : 0;
			d_cnt_q <= dmem_wait_o ? d_cnt_q + 1 : 0;
		end
	end
endmodule

/* pit_pkg.sv */
package pit_pkg;

	// Instruction classes presented at issue
	typedef enum logic [3:0] {
		CLS_DATA_OP = 4'h0,
		CLS_SINGLE_WORD_LOAD = 4'h1,
		CLS_SINGLE_WORD_STORE = 4'h2,
		CLS_BLOCK_LOAD = 4'h3,
		CLS_BLOCK_STORE = 4'h4,
		CLS_ATOMIC_SWAP = 4'h5,
		CLS_BRANCH = 4'h6,
		CLS_SOFTWARE_INTERRUPT = 4'h7,
		CLS_UNDEFINED = 4'h8,
		CLS_COPROC_DATA_OP = 4'h9,
		CLS_COPROC_MEM = 4'hA,
		CLS_CORE_TO_COPROC_MOVE = 4'hB,
		CLS_COPROC_TO_CORE_MOVE = 4'hC,
		CLS_MULTIPLY_32 = 4'hD,
		CLS_LONG_MULTIPLY = 4'hE
	} pit_cls_t;

	// Bus cycle types: internal, nonsequential, sequential, coprocessor
	typedef enum logic [1:0] {
		BUS_I = 2'h0,
		BUS_N = 2'h1,
		BUS_S = 2'h2,
		BUS_C = 2'h3
	} pit_bus_t;

	typedef enum logic {
		ST_IDLE = 1'h0,
		ST_RUN = 1'h1
	} pit_state_t;

	localparam int LEN_W = 6;
	localparam logic [3:0] PC_IDX = 4'hF;

	// Cycle counts
	localparam logic [LEN_W-1:0] ONE_CYC = 6'h01;
	localparam logic [LEN_W-1:0] SHIFT_REG_LEN = 6'h02;
	localparam logic [LEN_W-1:0] LOAD_USE_LEN = 6'h02;
	localparam logic [LEN_W-1:0] NARROW_USE_LEN = 6'h03;
	localparam logic [LEN_W-1:0] LOAD_PC_LEN = 6'h05;
	localparam logic [LEN_W-1:0] SINGLE_BLOCK_LEN = 6'h02;
	localparam logic [LEN_W-1:0] BLOCK_PC_EXTRA = 6'h04;
	localparam logic [LEN_W-1:0] SWAP_LEN = 6'h02;
	localparam logic [LEN_W-1:0] SWAP_USE_LEN = 6'h03;
	localparam logic [LEN_W-1:0] REFILL_LEN = 6'h03;
	localparam logic [LEN_W-1:0] MUL_BASE = 6'h02;
	localparam logic [LEN_W-1:0] MULL_BASE = 6'h03;

	// Early termination thresholds and operand field positions
	localparam int ET_LO = 8;
	localparam int ET_MID = 16;
	localparam int ET_HI = 24;
	localparam int MUL_RS_LSB = 8;
	localparam int MUL_RS_COMPACT_LSB = 0;

	// Reset values
	localparam logic [LEN_W-1:0] CNT_RST = 6'h00;
	localparam logic [3:0] REG_RST = 4'h0;

endpackage

/* tb.sv */
`timescale 1ns/1ps
module tb
	import pit_pkg::*;
();
	logic sys_clk_i = 1'b0;
	logic resetn_i;
	logic issue_valid_i;
	pit_cls_t cls_i;
	logic shift_by_reg_i;
	logic pc_dest_i;
	logic byte_load_i;
	logic [3:0] load_dest_i;
	logic [15:0] reg_list_i;
	logic [3:0] busy_wait_i;
	logic [4:0] cp_words_i;
	logic unsigned_long_i;
	logic [31:0] mul_operand_i;
	logic [31:0] instr_i;
	logic compact_i;
	logic [15:0] next_src_mask_i;
	logic imem_wait_i;
	logic dmem_wait_i;
	logic i_slow;
	logic d_slow;
	logic issue_ready_o;
	logic fetch_hold_o;
	logic instr_done_o;
	pit_bus_t ibus_type_o;
	pit_bus_t dbus_type_o;
	logic [3:0] mul_op_reg_o;
	int bad_count = 0;
	int n_tests = 0;
	int dn;
	int dc;
	int ib_s;
	int ib_n;

	pit_core_timing #(.BW(4), .CPW(5)) dut (.sys_clk_i, .resetn_i, .issue_valid_i, .cls_i,
		.shift_by_reg_i, .pc_dest_i, .byte_load_i, .load_dest_i, .reg_list_i, .busy_wait_i,
		.cp_words_i, .unsigned_long_i, .mul_operand_i, .instr_i, .compact_i, .next_src_mask_i,
		.imem_wait_i, .dmem_wait_i, .issue_ready_o, .fetch_hold_o, .instr_done_o,
		.ibus_type_o, .dbus_type_o, .mul_op_reg_o);

	pit_mem_model #(.LAT(2)) mem (.sys_clk_i, .resetn_i, .i_slow_i(i_slow), .d_slow_i(d_slow),
		.ibus_type_i(ibus_type_o), .dbus_type_i(dbus_type_o), .imem_wait_o(imem_wait_i),
		.dmem_wait_o(dmem_wait_i));

	always #4 sys_clk_i = ~sys_clk_i;

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	task automatic stop_test();
		if (bad_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Offer, wait for the take, then tally each cycle until the done pulse
	task automatic go(input int len, input int hold);
		int k;
		int h;
		int fh;
		k = 0;
		h = 0;
		fh = 0;
		dn = 0;
		dc = 0;
		ib_s = 0;
		ib_n = 0;
		issue_valid_i <= 1'b1;
		do begin
			@(posedge sys_clk_i);
			k++;
		end while (!(issue_ready_o === 1'b1 && !imem_wait_i && !dmem_wait_i) && k < 50);
		if (k >= 50) begin
			check("take", 0, 1);
			stop_test();
		end
		issue_valid_i <= 1'b0;
		k = 0;
		do begin
			@(posedge sys_clk_i);
			k++;
			if (fetch_hold_o === 1'b1) begin
				h++;
			end
			if (fetch_hold_o === 1'b1 && ibus_type_o !== BUS_I) begin
				fh++;
			end
			if (!imem_wait_i && !dmem_wait_i && dbus_type_o === BUS_N) begin
				dn++;
			end
			if (!imem_wait_i && !dmem_wait_i && dbus_type_o === BUS_C) begin
				dc++;
			end
			if (!imem_wait_i && !dmem_wait_i && ibus_type_o === BUS_S) begin
				ib_s++;
			end
			if (!imem_wait_i && !dmem_wait_i && ibus_type_o === BUS_N) begin
				ib_n++;
			end
		end while (instr_done_o !== 1'b1 && k < 200);
		if (k >= 200) begin
			check("done", 0, 1);
			stop_test();
		end
		check("cycles", k - 1, len);
		if (hold >= 0) begin
			check("interlock", h, hold);
		end
		check("fetch in interlock", fh, 0);
	endtask

	task automatic run(input pit_cls_t c, input int len, input int hold,
			input logic [15:0] src = 16'h0000, input logic [15:0] lst = 16'h0000,
			input logic [3:0] dst = 4'h0, input logic byt = 1'b0, input logic pcd = 1'b0,
			input logic sh = 1'b0);
		cls_i <= c;
		next_src_mask_i <= src;
		reg_list_i <= lst;
		load_dest_i <= dst;
		byte_load_i <= byt;
		pc_dest_i <= pcd;
		shift_by_reg_i <= sh;
		go(len, hold);
	endtask

	task automatic t_reset();
		check("ready", issue_ready_o, 32'h1);
		check("hold", fetch_hold_o, 32'h0);
		check("done", instr_done_o, 32'h0);
		check("ibus", ibus_type_o, BUS_I);
		check("dbus", dbus_type_o, BUS_I);
		check("op reg", mul_op_reg_o, 32'h0);
	endtask

	task automatic t_alu();
		run(CLS_DATA_OP, 1, 0);
		run(CLS_DATA_OP, 2, 0, 16'h0000, 16'h0000, 4'h0, 1'b0, 1'b0, 1'b1);
		check("dbus n", dn, 0);
		check("ibus s", ib_s, 1);
	endtask

	task automatic t_load();
		run(CLS_SINGLE_WORD_LOAD, 1, 0, 16'h0002);
		check("dbus n", dn, 1);
		run(CLS_SINGLE_WORD_LOAD, 2, 1, 16'h0001);
		run(CLS_SINGLE_WORD_LOAD, 3, 2, 16'h0001, 16'h0000, 4'h0, 1'b1);
		run(CLS_SINGLE_WORD_LOAD, 1, 0, 16'h0002, 16'h0000, 4'h0, 1'b1);
		run(CLS_SINGLE_WORD_LOAD, 5, -1, 16'h0000, 16'h0000, 4'hF, 1'b0, 1'b1);
		check("ibus n", ib_n, 1);
		check("ibus s", ib_s, 2);
		run(CLS_SINGLE_WORD_STORE, 1, 0, 16'h0001);
	endtask

	task automatic t_block();
		run(CLS_BLOCK_LOAD, 2, 0, 16'h0000, 16'h0002);
		run(CLS_BLOCK_LOAD, 3, 0, 16'h0002, 16'h000E);
		check("dbus n", dn, 1);
		run(CLS_BLOCK_LOAD, 4, 1, 16'h0008, 16'h000E);
		run(CLS_BLOCK_LOAD, 6, -1, 16'h0000, 16'h8002, 4'h0, 1'b0, 1'b1);
		run(CLS_BLOCK_STORE, 2, 0, 16'h0000, 16'h0001);
		run(CLS_BLOCK_STORE, 5, 0, 16'h0000, 16'h001F);
	endtask

	task automatic t_swap();
		run(CLS_ATOMIC_SWAP, 2, 0, 16'h0004, 16'h0000, 4'h2);
		check("dbus n", dn, 2);
		run(CLS_ATOMIC_SWAP, 3, 1, 16'h0004, 16'h0000, 4'h2, 1'b1);
	endtask

	task automatic t_refill();
		pit_cls_t cl [3] = '{CLS_BRANCH, CLS_SOFTWARE_INTERRUPT, CLS_UNDEFINED};
		for (int i = 0; i < 3; i++) begin
			run(cl[i], 3, 0);
			check("ibus n", ib_n, 1);
			check("ibus s", ib_s, 2);
		end
	endtask

	task automatic t_coproc();
		busy_wait_i <= 4'h3;
		cp_words_i <= 5'h03;
		run(CLS_COPROC_DATA_OP, 4, -1);
		run(CLS_CORE_TO_COPROC_MOVE, 4, -1);
		check("dbus c", dc, 1);
		run(CLS_COPROC_TO_CORE_MOVE, 4, -1, 16'h0001, 16'h0000, 4'h5);
		run(CLS_COPROC_TO_CORE_MOVE, 5, -1, 16'h0020, 16'h0000, 4'h5);
		run(CLS_COPROC_MEM, 6, -1);
		check("dbus n", dn, 1);
		busy_wait_i <= 4'h0;
		run(CLS_COPROC_MEM, 3, -1);
	endtask

	task automatic t_mul();
		logic [31:0] ops [6] = '{32'h000000FF, 32'hFFFFFF80, 32'h0000FF00, 32'h00FF0000,
			32'hFF800000, 32'h12345678};
		int ms [6] = '{1, 1, 2, 3, 3, 4};
		int mu [6] = '{1, 4, 2, 3, 4, 4};
		for (int i = 0; i < 6; i++) begin
			mul_operand_i <= ops[i];
			unsigned_long_i <= 1'b0;
			run(CLS_MULTIPLY_32, 2 + ms[i], -1);
			run(CLS_LONG_MULTIPLY, 3 + ms[i], -1);
			unsigned_long_i <= 1'b1;
			run(CLS_LONG_MULTIPLY, 3 + mu[i], -1);
		end
		unsigned_long_i <= 1'b0;
		instr_i <= 32'h00000A00;
		run(CLS_MULTIPLY_32, 6, -1);
		check("op reg", mul_op_reg_o, 32'hA);
		instr_i <= 32'h00000F05;
		compact_i <= 1'b1;
		run(CLS_MULTIPLY_32, 6, -1);
		check("op reg", mul_op_reg_o, 32'h5);
	endtask

	task automatic t_wait();
		d_slow <= 1'b1;
		run(CLS_SINGLE_WORD_LOAD, 3, -1);
		d_slow <= 1'b0;
		i_slow <= 1'b1;
		run(CLS_DATA_OP, 3, -1);
		i_slow <= 1'b0;
	endtask

	// Second offer held through the last cycle of the first is taken at once
	task automatic t_b2b();
		cls_i <= CLS_DATA_OP;
		shift_by_reg_i <= 1'b0;
		issue_valid_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		check("b2b ready", issue_ready_o, 32'h1);
		issue_valid_i <= 1'b0;
		@(posedge sys_clk_i);
		check("b2b done first", instr_done_o, 32'h1);
		check("b2b ibus", ibus_type_o, BUS_S);
		@(posedge sys_clk_i);
		check("b2b done second", instr_done_o, 32'h1);
		@(posedge sys_clk_i);
		check("b2b idle", instr_done_o, 32'h0);
	endtask

	// Reset in the middle of a long instruction must return every output to idle
	task automatic t_midreset();
		cls_i <= CLS_BLOCK_STORE;
		reg_list_i <= 16'h00FF;
		issue_valid_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		issue_valid_i <= 1'b0;
		resetn_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		t_reset();
		resetn_i <= 1'b1;
		run(CLS_DATA_OP, 1, 0);
	endtask

	initial begin
		resetn_i = 1'b0;
		issue_valid_i = 1'b0;
		cls_i = CLS_DATA_OP;
		shift_by_reg_i = 1'b0;
		pc_dest_i = 1'b0;
		byte_load_i = 1'b0;
		load_dest_i = 4'h0;
		reg_list_i = 16'h0000;
		busy_wait_i = 4'h0;
		cp_words_i = 5'h00;
		unsigned_long_i = 1'b0;
		mul_operand_i = 32'h00000000;
		instr_i = 32'h00000000;
		compact_i = 1'b0;
		next_src_mask_i = 16'h0000;
		i_slow = 1'b0;
		d_slow = 1'b0;
		repeat (8) @(posedge sys_clk_i);
		t_reset();
		resetn_i <= 1'b1;
		t_alu();
		t_load();
		t_block();
		t_swap();
		t_refill();
		t_coproc();
		t_mul();
		t_wait();
		t_b2b();
		t_midreset();
		stop_test();
	end
endmodule
